// ===== hdl/debug_trace_port.sv
`timescale 1ns/1ps

module debug_trace_port #(
  parameter int PACKET_BITS = debug_port_pkg::PACKET_BITS
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic test_clock_i,
  input wire logic test_reset_n_i,
  input wire logic test_mode_select_i,
  input wire logic test_data_in_i,
  output logic test_data_out_o,
  output logic test_data_out_en_o,
  input wire logic debug_serial_clock_i,
  input wire logic debug_serial_in_i,
  output logic debug_serial_out_o,
  output logic [PACKET_BITS-1:0] debug_command_o,
  output logic debug_command_valid_o,
  input wire logic [PACKET_BITS-1:0] debug_response_i,
  input wire logic breakpoint_request_n_i,
  output logic breakpoint_o,
  input wire logic core_begin_one_i,
  input wire logic core_user_entry_i,
  input wire logic core_pulse_write_i,
  input wire logic core_taken_branch_i,
  input wire logic core_exc_return_i,
  input wire logic core_exception_i,
  input wire logic core_stopped_i,
  input wire logic core_halted_i,
  input wire logic trace_valid_i,
  input wire logic [1:0] trace_bytes_i,
  input wire logic [31:0] trace_word_i,
  output logic trace_ready_o,
  output logic [3:0] core_status_code_o,
  output logic [3:0] trace_data_nibble_o
);

  // status priority; reserved codes have no path here
  function automatic logic [3:0] status_of(
    input logic halted,
    input logic stopped,
    input logic exception,
    input logic trace_start,
    input logic [1:0] bytes,
    input logic exc_return,
    input logic pulse_write,
    input logic branch,
    input logic user_entry,
    input logic begin_one
  );
    logic [3:0] code;
    code = debug_port_pkg::STATUS_CONTINUE;
    if (halted) begin
      code = debug_port_pkg::STATUS_HALTED;
    end else if (stopped) begin
      code = debug_port_pkg::STATUS_STOPPED;
    end else if (exception) begin
      code = debug_port_pkg::STATUS_EXCEPTION;
    end else if (trace_start) begin
      code = debug_port_pkg::STATUS_TRACE_BASE | {2'h0, bytes};
    end else if (exc_return) begin
      code = debug_port_pkg::STATUS_EXC_RETURN;
    end else if (pulse_write) begin
      code = debug_port_pkg::STATUS_PULSE_WRITE;
    end else if (branch) begin
      code = debug_port_pkg::STATUS_TAKEN_BRANCH;
    end else if (user_entry) begin
      code = debug_port_pkg::STATUS_USER_ENTRY;
    end else if (begin_one) begin
      code = debug_port_pkg::STATUS_BEGIN_ONE;
    end
    return code;
  endfunction

  // ---- test clock side
  logic halted_tck_meta;
  logic halted_tck;
  logic break_level_tck;

  // halted level into the test clock domain
  always_ff @(posedge test_clock_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      halted_tck_meta <= 1'b0;
      halted_tck <= 1'b0;
    end else begin
      halted_tck_meta <= core_halted_i;
      halted_tck <= halted_tck_meta;
    end
  end

  test_access_port tap (
    .test_clock_i(test_clock_i),
    .test_reset_n_i(test_reset_n_i),
    .test_mode_select_i(test_mode_select_i),
    .test_data_in_i(test_data_in_i),
    .status_capture_i({3'h0, halted_tck}),
    .test_data_out_o(test_data_out_o),
    .test_data_out_en_o(test_data_out_en_o),
    .break_level_o(break_level_tck)
  );

  // ---- processor clock side: pin synchronisers
  logic brk_meta;
  logic brk_sync;
  logic brk_prev;
  logic jtag_brk_meta;
  logic jtag_brk_sync;
  logic jtag_brk_prev;
  logic sclk_meta;
  logic sclk_sync;
  logic sclk_prev;
  logic sdi_meta;
  logic sdi_sync;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      brk_meta <= 1'b1;
      brk_sync <= 1'b1;
      brk_prev <= 1'b1;
      jtag_brk_meta <= 1'b0;
      jtag_brk_sync <= 1'b0;
      jtag_brk_prev <= 1'b0;
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
    end else begin
      brk_meta <= breakpoint_request_n_i;
      brk_sync <= brk_meta;
      brk_prev <= brk_sync;
      jtag_brk_meta <= break_level_tck;
      jtag_brk_sync <= jtag_brk_meta;
      jtag_brk_prev <= jtag_brk_sync;
      sclk_meta <= debug_serial_clock_i;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      sdi_meta <= debug_serial_in_i;
      sdi_sync <= sdi_meta;
    end
  end

  // ---- manual breakpoint
  logic brk_fall;
  logic jtag_brk_rise;
  assign brk_fall = brk_prev & ~brk_sync;
  assign jtag_brk_rise = jtag_brk_sync & ~jtag_brk_prev;

  // hold the request until the core halts
  // a new request in the halting cycle wins over the clear
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      breakpoint_o <= 1'b0;
    end else if (brk_fall || jtag_brk_rise) begin
      breakpoint_o <= 1'b1;
    end else if (core_halted_i) begin
      breakpoint_o <= 1'b0;
    end
  end

  // ---- serial debug packets
  logic sclk_rise;
  logic sclk_fall;
  logic [PACKET_BITS-1:0] rx_shift;
  logic [PACKET_BITS-1:0] tx_shift;
  logic [4:0] bit_count;
  logic packet_done;
  assign sclk_rise = sclk_sync & ~sclk_prev;
  assign sclk_fall = sclk_prev & ~sclk_sync;
  assign packet_done = sclk_rise &&
                       (bit_count == 5'(PACKET_BITS - 1));

  // edges come from the synced copy of the debugger clock
  // bits advance only on debugger clock edges
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_shift <= '0;
      bit_count <= 5'h0;
    end else if (sclk_rise) begin
      rx_shift <= {rx_shift[PACKET_BITS-2:0], sdi_sync};
      bit_count <= packet_done ? 5'h0 : 5'(bit_count + 5'h1);
    end
  end

  // command word handed to the core for one cycle
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      debug_command_o <= '0;
      debug_command_valid_o <= 1'b0;
    end else begin
      debug_command_valid_o <= packet_done;
      if (packet_done) begin
        debug_command_o <= {rx_shift[PACKET_BITS-2:0], sdi_sync};
      end
    end
  end

  // response loads at packet end, then shifts msb first on falling edges
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_shift <= '0;
    end else if (packet_done) begin
      tx_shift <= debug_response_i;
    end else if (sclk_fall) begin
      tx_shift <= {tx_shift[PACKET_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      debug_serial_out_o <= 1'b0;
    end else if (sclk_fall) begin
      debug_serial_out_o <= tx_shift[PACKET_BITS-1];
    end
  end

  // ---- trace data stream
  logic trace_take;
  logic [31:0] trace_word;
  logic [3:0] nibbles_left;
  logic [3:0] next_nibbles_left;
  assign trace_take = trace_valid_i & trace_ready_o;

  // nibble count; a new word may start right after the last nibble
  always_comb begin
    next_nibbles_left = nibbles_left;
    if (trace_take) begin
      next_nibbles_left = 4'((4'({2'h0, trace_bytes_i}) + 4'h1) *
                             debug_port_pkg::NIBBLES_PER_BYTE);
    end else if (nibbles_left != 4'h0) begin
      next_nibbles_left = 4'(nibbles_left - 4'h1);
    end
  end

  // ready stands from a flop so the core sees a clean handshake
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nibbles_left <= 4'h0;
      trace_ready_o <= 1'b1;
    end else begin
      nibbles_left <= next_nibbles_left;
      trace_ready_o <= (next_nibbles_left == 4'h0);
    end
  end

  // one nibble per clock, low nibble first
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trace_word <= 32'h0000_0000;
    end else if (trace_take) begin
      trace_word <= trace_word_i;
    end else if (nibbles_left != 4'h0) begin
      trace_word <= {4'h0, trace_word[31:4]};
    end
  end

  // data while streaming, breakpoint status between
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trace_data_nibble_o <= 4'h0;
    end else if (nibbles_left != 4'h0) begin
      trace_data_nibble_o <= trace_word[3:0];
    end else begin
      trace_data_nibble_o <= {2'h0, jtag_brk_sync, breakpoint_o};
    end
  end

  // ---- core status
  // processor clock only, no bus timing involved
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_status_code_o <= debug_port_pkg::STATUS_CONTINUE;
    end else begin
      core_status_code_o <= status_of(core_halted_i, core_stopped_i,
                                      core_exception_i, trace_take,
                                      trace_bytes_i, core_exc_return_i,
                                      core_pulse_write_i,
                                      core_taken_branch_i,
                                      core_user_entry_i, core_begin_one_i);
    end
  end

endmodule

// ===== shared/debug_port_pkg.sv
package debug_port_pkg;

  // core status codes driven on core_status_code_o
  localparam logic [3:0] STATUS_CONTINUE = 4'h0;
  localparam logic [3:0] STATUS_BEGIN_ONE = 4'h1;
  localparam logic [3:0] STATUS_USER_ENTRY = 4'h3;
  localparam logic [3:0] STATUS_PULSE_WRITE = 4'h4;
  localparam logic [3:0] STATUS_TAKEN_BRANCH = 4'h5;
  localparam logic [3:0] STATUS_EXC_RETURN = 4'h7;
  localparam logic [3:0] STATUS_TRACE_BASE = 4'h8;
  localparam logic [3:0] STATUS_EXCEPTION = 4'hc;
  localparam logic [3:0] STATUS_STOPPED = 4'he;
  localparam logic [3:0] STATUS_HALTED = 4'hf;

  // trace data layout
  localparam int TRACE_WORD_BITS = 32;
  localparam int NIBBLE_BITS = 4;
  localparam logic [3:0] NIBBLES_PER_BYTE = 4'h2;

  // test access port instruction register
  localparam int IR_BITS = 4;
  localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_STATUS = 4'h2;
  localparam logic [3:0] IR_BREAK = 4'h3;
  localparam logic [3:0] IR_RESET_VALUE = IR_BYPASS;

  // serial debug packet
  localparam int PACKET_BITS = 17;
  localparam logic [16:0] PACKET_RESET_VALUE = 17'h0_0000;

  // test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET = 4'b0000,
    TAP_IDLE = 4'b0001,
    TAP_SEL_DR = 4'b0010,
    TAP_CAP_DR = 4'b0011,
    TAP_SHIFT_DR = 4'b0100,
    TAP_EXIT1_DR = 4'b0101,
    TAP_PAUSE_DR = 4'b0110,
    TAP_EXIT2_DR = 4'b0111,
    TAP_UPD_DR = 4'b1000,
    TAP_SEL_IR = 4'b1001,
    TAP_CAP_IR = 4'b1010,
    TAP_SHIFT_IR = 4'b1011,
    TAP_EXIT1_IR = 4'b1100,
    TAP_PAUSE_IR = 4'b1101,
    TAP_EXIT2_IR = 4'b1110,
    TAP_UPD_IR = 4'b1111
  } tap_state_t;

endpackage

// ===== hdl/test_access_port.sv
`timescale 1ns/1ps

// boundary-scan controller; runs entirely on the test clock
module test_access_port (
  input wire logic test_clock_i,
  input wire logic test_reset_n_i,
  input wire logic test_mode_select_i,
  input wire logic test_data_in_i,
  input wire logic [3:0] status_capture_i,
  output logic test_data_out_o,
  output logic test_data_out_en_o,
  output logic break_level_o
);

  debug_port_pkg::tap_state_t state;
  debug_port_pkg::tap_state_t next_state;
  logic [3:0] ir;
  logic [3:0] ir_shift;
  logic [3:0] dr_shift;

  // next state from the mode select level
  always_comb begin
    next_state = state;
    case (state)
      debug_port_pkg::TAP_RESET: next_state = test_mode_select_i ?
        debug_port_pkg::TAP_RESET : debug_port_pkg::TAP_IDLE;
      debug_port_pkg::TAP_IDLE: next_state = test_mode_select_i ?
        debug_port_pkg::TAP_SEL_DR : debug_port_pkg::TAP_IDLE;
      debug_port_pkg::TAP_SEL_DR: next_state = test_mode_select_i ?
        debug_port_pkg::TAP_SEL_IR : debug_port_pkg::TAP_CAP_DR;
      debug_port_pkg::TAP_CAP_DR, debug_port_pkg::TAP_SHIFT_DR:
        next_state = test_mode_select_i ?
          debug_port_pkg::TAP_EXIT1_DR : debug_port_pkg::TAP_SHIFT_DR;
      debug_port_pkg::TAP_EXIT1_DR: next_state = test_mode_select_i ?
        debug_port_pkg::TAP_UPD_DR : debug_port_pkg::TAP_PAUSE_DR;
      debug_port_pkg::TAP_PAUSE_DR: next_state = test_mode_select_i ?
        debug_port_pkg::TAP_EXIT2_DR : debug_port_pkg::TAP_PAUSE_DR;
      debug_port_pkg::TAP_EXIT2_DR: next_state = test_mode_select_i ?
        debug_port_pkg::TAP_UPD_DR : debug_port_pkg::TAP_SHIFT_DR;
      debug_port_pkg::TAP_UPD_DR, debug_port_pkg::TAP_UPD_IR:
        next_state = test_mode_select_i ?
          debug_port_pkg::TAP_SEL_DR : debug_port_pkg::TAP_IDLE;
      debug_port_pkg::TAP_SEL_IR: next_state = test_mode_select_i ?
        debug_port_pkg::TAP_RESET : debug_port_pkg::TAP_CAP_IR;
      debug_port_pkg::TAP_CAP_IR, debug_port_pkg::TAP_SHIFT_IR:
        next_state = test_mode_select_i ?
          debug_port_pkg::TAP_EXIT1_IR : debug_port_pkg::TAP_SHIFT_IR;
      debug_port_pkg::TAP_EXIT1_IR: next_state = test_mode_select_i ?
        debug_port_pkg::TAP_UPD_IR : debug_port_pkg::TAP_PAUSE_IR;
      debug_port_pkg::TAP_PAUSE_IR: next_state = test_mode_select_i ?
        debug_port_pkg::TAP_EXIT2_IR : debug_port_pkg::TAP_PAUSE_IR;
      debug_port_pkg::TAP_EXIT2_IR: next_state = test_mode_select_i ?
        debug_port_pkg::TAP_UPD_IR : debug_port_pkg::TAP_SHIFT_IR;
      default: next_state = debug_port_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge test_clock_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      state <= debug_port_pkg::TAP_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge test_clock_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      ir_shift <= debug_port_pkg::IR_RESET_VALUE;
      dr_shift <= 4'h0;
      ir <= debug_port_pkg::IR_RESET_VALUE;
    end else begin
      case (state)
        debug_port_pkg::TAP_RESET: ir <= debug_port_pkg::IR_RESET_VALUE;
        debug_port_pkg::TAP_CAP_IR:
          ir_shift <= debug_port_pkg::IR_CAPTURE_VALUE;
        debug_port_pkg::TAP_SHIFT_IR:
          ir_shift <= {test_data_in_i, ir_shift[3:1]};
        debug_port_pkg::TAP_UPD_IR: ir <= ir_shift;
        debug_port_pkg::TAP_CAP_DR: dr_shift <= status_capture_i;
        debug_port_pkg::TAP_SHIFT_DR: begin
          // only the status path is four bits long, every other instruction gets a one-bit path
          if (ir == debug_port_pkg::IR_STATUS) begin
            dr_shift <= {test_data_in_i, dr_shift[3:1]};
          end else begin
            dr_shift <= {3'h0, test_data_in_i};
          end
        end
        default: ir <= ir;
      endcase
    end
  end

  // break level follows the instruction being loaded, so a tester that
  // stops its clock right after update still gets the break
  always_ff @(posedge test_clock_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      break_level_o <= 1'b0;
    end else if (state == debug_port_pkg::TAP_UPD_IR) begin
      break_level_o <= (ir_shift == debug_port_pkg::IR_BREAK);
    end else begin
      break_level_o <= (ir == debug_port_pkg::IR_BREAK);
    end
  end

  always_ff @(negedge test_clock_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      test_data_out_o <= 1'b0;
      test_data_out_en_o <= 1'b0;
    end else begin
      test_data_out_en_o <= (state == debug_port_pkg::TAP_SHIFT_IR) ||
                            (state == debug_port_pkg::TAP_SHIFT_DR);
      test_data_out_o <= (state == debug_port_pkg::TAP_SHIFT_IR) ?
                         ir_shift[0] : dr_shift[0];
    end
  end

endmodule

// ===== bench/debug_trace_port_props.sv
`timescale 1ns/1ps

// pin-level checks on the processor clock side of the trace port, plus the scan output in test reset
module debug_trace_port_props (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic test_reset_n_i,
  input wire logic test_data_out_o,
  input wire logic test_data_out_en_o,
  input wire logic debug_command_valid_o,
  input wire logic breakpoint_o,
  input wire logic core_begin_one_i,
  input wire logic core_user_entry_i,
  input wire logic core_pulse_write_i,
  input wire logic core_taken_branch_i,
  input wire logic core_exc_return_i,
  input wire logic core_exception_i,
  input wire logic core_stopped_i,
  input wire logic core_halted_i,
  input wire logic trace_valid_i,
  input wire logic [1:0] trace_bytes_i,
  input wire logic [31:0] trace_word_i,
  input wire logic trace_ready_o,
  input wire logic [3:0] core_status_code_o,
  input wire logic [3:0] trace_data_nibble_o
);
  logic take;
  logic above;
  logic top3;
  // a taken word, and anything outranking the begin-one code
  assign take = trace_valid_i && trace_ready_o;
  assign top3 = core_halted_i || core_stopped_i || core_exception_i;
  assign above = top3 || take || core_exc_return_i || core_pulse_write_i ||
    core_taken_branch_i || core_user_entry_i;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_reserved;
    !(core_status_code_o inside {4'h2, 4'h6, 4'hd});
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status code seen");
  property p_halted;
    core_halted_i |=> core_status_code_o == debug_port_pkg::STATUS_HALTED;
  endproperty
  a_halted: assert property (p_halted)
    else $error("halted code missing");
  property p_stopped;
    core_stopped_i && !core_halted_i |=>
      core_status_code_o == debug_port_pkg::STATUS_STOPPED;
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("stopped code missing");
  property p_begin;
    core_begin_one_i && !above |=>
      core_status_code_o == debug_port_pkg::STATUS_BEGIN_ONE;
  endproperty
  a_begin: assert property (p_begin)
    else $error("begin code missing");
  property p_idle;
    !core_begin_one_i && !above |=> core_status_code_o == 4'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle code wrong");
  property p_trace_code;
    take && !top3 |=> core_status_code_o == {2'b10, $past(trace_bytes_i)};
  endproperty
  a_trace_code: assert property (p_trace_code)
    else $error("trace announce code wrong");
  property p_busy;
    take |=> !trace_ready_o;
  endproperty
  a_busy: assert property (p_busy)
    else $error("ready while streaming");
  property p_nibbles;
    take |-> ##2 trace_data_nibble_o == $past(trace_word_i[3:0], 2)
      ##1 trace_data_nibble_o == $past(trace_word_i[7:4], 3);
  endproperty
  a_nibbles: assert property (p_nibbles)
    else $error("trace nibble order wrong");
  property p_cmd_pulse;
    debug_command_valid_o |=> !debug_command_valid_o;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command valid longer than one cycle");
  property p_break_hold;
    breakpoint_o && !core_halted_i |=> breakpoint_o;
  endproperty
  a_break_hold: assert property (p_break_hold)
    else $error("breakpoint dropped before halt");
  property p_test_reset;
    !test_reset_n_i |-> !test_data_out_en_o && !test_data_out_o;
  endproperty
  a_test_reset: assert property (p_test_reset)
    else $error("scan output active in test reset");
endmodule

// ===== bench/debug_host_model.sv
`timescale 1ns/1ps

// debugger and scan tester facing the debug pins
module debug_host_model (
  output logic test_clock_o,
  output logic test_mode_select_o,
  output logic test_data_in_o,
  input wire logic test_data_out_i,
  input wire logic test_data_out_en_i,
  output logic serial_clock_o,
  output logic serial_data_o,
  input wire logic serial_out_i
);
  // both clocks stand low between frames
  initial begin
    test_clock_o = 1'b0;
    test_mode_select_o = 1'b1;
    test_data_in_o = 1'b0;
    serial_clock_o = 1'b0;
    serial_data_o = 1'b0;
  end

  // host paces each bit
  // half period of 100 ns leaves the synchroniser five clocks
  task automatic send(input logic [16:0] cmd, output logic [16:0] rsp);
    for (int i = 16; i >= 0; i--) begin
      serial_data_o = cmd[i];
      #100;
      rsp[i] = serial_out_i;
      serial_clock_o = 1'b1;
      #100;
      serial_clock_o = 1'b0;
    end
    #100;
    serial_data_o = ~cmd[0];  // released line shows no stale bit
  endtask

  // outputs read well after they settle
  // one test clock of 30 ns; output read after its falling edge
  task automatic step(input logic tms, input logic tdi, output logic tdo,
                      output logic en);
    test_mode_select_o = tms;
    test_data_in_o = tdi;
    #13;
    test_clock_o = 1'b1;
    #15;
    test_clock_o = 1'b0;
    #2;
    tdo = test_data_out_i;
    en = test_data_out_en_i;
  endtask
endmodule

// ===== bench/debug_trace_port_bench.sv
`timescale 1ns/1ps

module debug_trace_port_bench;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic trst_n = 1'b0;
  logic tck, tms, tdi, tdo, tdo_en, sclk, sdi, sdo, cmd_valid, bp, rdy;
  logic breakpoint_request_n_n = 1'b1;
  logic tvalid = 1'b0;
  logic [1:0] tbytes = 2'b00;
  logic [31:0] tword = 32'h0000_0000;
  logic [16:0] resp = 17'h0_0000;
  logic [16:0] cmd;
  logic [7:0] ev = 8'h00;
  logic [3:0] code, nib;
  logic [3:0] st_q[$];
  logic [3:0] nib_q[$];
  logic [16:0] cmd_q[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int pend = 0;
  int cyc = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  debug_trace_port dut_u (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .test_clock_i(tck),
    .test_reset_n_i(trst_n), .test_mode_select_i(tms),
    .test_data_in_i(tdi), .test_data_out_o(tdo),
    .test_data_out_en_o(tdo_en), .debug_serial_clock_i(sclk),
    .debug_serial_in_i(sdi), .debug_serial_out_o(sdo),
    .debug_command_o(cmd), .debug_command_valid_o(cmd_valid),
    .debug_response_i(resp), .breakpoint_request_n_i(breakpoint_request_n_n),
    .breakpoint_o(bp), .core_begin_one_i(ev[0]),
    .core_user_entry_i(ev[1]), .core_taken_branch_i(ev[2]),
    .core_pulse_write_i(ev[3]), .core_exc_return_i(ev[4]),
    .core_exception_i(ev[5]), .core_stopped_i(ev[6]),
    .core_halted_i(ev[7]), .trace_valid_i(tvalid),
    .trace_bytes_i(tbytes), .trace_word_i(tword), .trace_ready_o(rdy),
    .core_status_code_o(code), .trace_data_nibble_o(nib)
  );

  debug_host_model host_u (
    .test_clock_o(tck), .test_mode_select_o(tms), .test_data_in_o(tdi),
    .test_data_out_i(tdo), .test_data_out_en_i(tdo_en),
    .serial_clock_o(sclk), .serial_data_o(sdi), .serial_out_i(sdo)
  );

  task automatic chk_code(input string what, input logic [3:0] exp,
                          input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [16:0] exp,
                          input logic [16:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic tick;
    @(posedge sys_clk_i);
    #1;
  endtask

  // expected code: highest-ranked core event wins
  function automatic logic [3:0] prio(input logic [7:0] e);
    logic [3:0] tab [8];
    tab = '{debug_port_pkg::STATUS_BEGIN_ONE,
      debug_port_pkg::STATUS_USER_ENTRY,
      debug_port_pkg::STATUS_TAKEN_BRANCH, debug_port_pkg::STATUS_PULSE_WRITE,
      debug_port_pkg::STATUS_EXC_RETURN, debug_port_pkg::STATUS_EXCEPTION,
      debug_port_pkg::STATUS_STOPPED, debug_port_pkg::STATUS_HALTED};
    for (int i = 7; i >= 0; i--) if (e[i]) return tab[i];
    return debug_port_pkg::STATUS_CONTINUE;
  endfunction

  // offer one word, held until ready was seen high at an edge
  task automatic trace_send(input logic [1:0] b, input logic [31:0] w);
    logic r;
    for (int i = 0; i < 2 * (int'(b) + 1); i++) nib_q.push_back(w[4*i+:4]);
    tvalid = 1'b1;
    tbytes = b;
    tword = w;
    r = 1'b0;
    for (int n = 0; n < 20 && !r; n++) begin
      @(negedge sys_clk_i);
      r = rdy;
      tick;
    end
    chk_code("ready", 4'h1, {3'b000, r});
  endtask

  task automatic wait_bp(input logic lvl);
    for (int n = 0; n < 50 && bp !== lvl; n++) tick;
    chk_code("breakpoint", {3'b000, lvl}, {3'b000, bp});
  endtask

  // outputs are compared mid-cycle, once settled
  always @(negedge sys_clk_i) begin
    if (st_q.size() > 0)
      chk_code("status", st_q.pop_front(), code);
    if (pend > 0) begin
      chk_code("nibble", nib_q.pop_front(), nib);
      pend--;
    end
    if (code[3:2] == 2'b10) pend += 2 * (int'(code[1:0]) + 1);
    if (cmd_valid) chk_word("command", cmd_q.pop_front(), cmd);
  end

  // the whole run needs well under 2000 cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      finish_test;
    end
  end

  initial begin
    logic [16:0] p, rsp;
    logic o, e;
    logic [3:0] ir;
    logic [15:0] ts, td;
    void'($urandom(32'hc1a8));
    repeat (3) @(posedge sys_clk_i);
    #1;
    rstn_i = 1'b1;
    trst_n = 1'b1;
    repeat (2) tick;
    for (int i = 0; i < 40; i++) begin
      ev = (i < 8) ? 8'h01 << i : (i == 8) ? 8'h00 : 8'($urandom);
      @(posedge sys_clk_i);
      st_q.push_back(prio(ev));
      #1;
    end
    ev = 8'h00;
    repeat (2) tick;
    $display("status test done");
    for (int i = 0; i < 4; i++) trace_send(2'(i), $urandom);
    tvalid = 1'b0;
    repeat (12) tick;
    $display("trace test done");
    resp = 17'($urandom);
    for (int i = 0; i < 2; i++) begin
      p = 17'($urandom);
      cmd_q.push_back(p);
      host_u.send(p, rsp);
    end
    chk_word("response", resp, rsp);
    repeat (10) tick;
    $display("serial test done");
    trst_n = 1'b0;
    #5;
    chk_code("scan enable", 4'h0, {3'b000, tdo_en});
    trst_n = 1'b1;
    host_u.step(1'b0, 1'b0, o, e);
    host_u.step(1'b1, 1'b0, o, e);
    host_u.step(1'b1, 1'b0, o, e);
    host_u.step(1'b0, 1'b0, o, e);
    chk_code("scan enable", 4'h0, {3'b000, e});
    host_u.step(1'b0, 1'b0, ir[0], e);
    chk_code("scan enable", 4'h1, {3'b000, e});
    for (int i = 0; i < 4; i++) begin
      host_u.step(i == 3, debug_port_pkg::IR_BREAK[i], o, e);
      if (i < 3) ir[i+1] = o;
    end
    chk_code("scan enable", 4'h0, {3'b000, e});
    chk_code("capture", debug_port_pkg::IR_CAPTURE_VALUE, ir);
    host_u.step(1'b1, 1'b0, o, e);
    host_u.step(1'b0, 1'b0, o, e);
    wait_bp(1'b1);
    ev = 8'h80;
    wait_bp(1'b0);
    ev = 8'h00;
    tick;
    breakpoint_request_n_n = 1'b0;
    repeat (2) tick;
    breakpoint_request_n_n = 1'b1;
    wait_bp(1'b1);
    ev = 8'h80;
    wait_bp(1'b0);
    // load the status instruction, read the halted level back in shift-DR
    ts = 16'h0583;
    td = 16'h0020;
    for (int i = 0; i < 13; i++) host_u.step(ts[i], td[i], o, e);
    chk_code("scan status", 4'h3, {2'b00, e, o});
    // test reset in the middle of a shift must release the pin at once
    trst_n = 1'b0;
    #5;
    chk_code("scan reset", 4'h0, {2'b00, tdo_en, tdo});
    trst_n = 1'b1;
    ev = 8'h00;
    repeat (5) tick;
    $display("scan and breakpoint test done");
    finish_test;
  end
endmodule

bind debug_trace_port debug_trace_port_props props_u (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .test_reset_n_i(test_reset_n_i),
  .test_data_out_o(test_data_out_o),
  .test_data_out_en_o(test_data_out_en_o),
  .debug_command_valid_o(debug_command_valid_o), .breakpoint_o(breakpoint_o),
  .core_begin_one_i(core_begin_one_i), .core_user_entry_i(core_user_entry_i),
  .core_pulse_write_i(core_pulse_write_i),
  .core_taken_branch_i(core_taken_branch_i),
  .core_exc_return_i(core_exc_return_i), .core_exception_i(core_exception_i),
  .core_stopped_i(core_stopped_i), .core_halted_i(core_halted_i),
  .trace_valid_i(trace_valid_i), .trace_bytes_i(trace_bytes_i),
  .trace_word_i(trace_word_i), .trace_ready_o(trace_ready_o),
  .core_status_code_o(core_status_code_o),
  .trace_data_nibble_o(trace_data_nibble_o)
);
